// File: hw/mssl_map.vh
`ifndef MSSL_MAP_VH
`define MSSL_MAP_VH
// operating modes
`define MSSL_MODE_SINGLE 2'h0
`define MSSL_MODE_SELFCHK 2'h1
`define MSSL_MODE_FACTORY 2'h2
// self-check routine selection
`define MSSL_RT_SELFCHK 3'h0
`define MSSL_RT_NOPLL 3'h1
`define MSSL_RT_JUMPRAM 3'h2
`define MSSL_RT_LOADRAM 3'h3
`define MSSL_RT_NONE 3'h4
// result codes on result lines 3..0 (low lights led)
`define MSSL_RES_BAD_IO 4'h9
`define MSSL_RES_BAD_RAM 4'hA
`define MSSL_RES_BAD_TMR 4'hB
`define MSSL_RES_BAD_ROM 4'hC
`define MSSL_RES_BAD_INT 4'hD
`define MSSL_RES_OFF 4'hF
`define MSSL_RES_ON 4'h0
// memory placement
`define MSSL_SC_ROM_LO 13'h1F00
`define MSSL_SC_ROM_HI 13'h1FEF
`define MSSL_ROMSUM_ENTRY 13'h1FD1
`define MSSL_TMRTEST_ENTRY 13'h1F9B
`define MSSL_RAM_START 13'h0100
// timing
`define MSSL_CLK_HZ 20000000
`define MSSL_POR_RESET_CYCLES 4064
`define MSSL_TMR_SAMPLE_CYCLES 4'hC
`define MSSL_FLASH_HALF_CYCLES 32'd10000000
// wishbone register offsets
`define MSSL_REG_CTRL 8'h00
`define MSSL_REG_STAT 8'h04
`define MSSL_REG_TEST 8'h08
`define MSSL_REG_CNT 8'h0C
// control field positions
`define MSSL_CTRL_RUN 0
`define MSSL_CTRL_CLR 1
// test fault injection field positions
`define MSSL_TEST_IO 0
`define MSSL_TEST_RAM 1
`define MSSL_TEST_TMR 2
`define MSSL_TEST_ROM 3
`define MSSL_TEST_INT 4
`endif

// File: hw/mssl_fifo.v
`timescale 1ns/100ps
// small synchronous fifo between download port and ram writer
module mssl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ff; // write pointer
  reg [AW-1:0] rd_ff; // read pointer
  reg [AW:0] cnt_ff; // fill level
  wire push;
  wire pop;
  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // storage write, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end
  // pointers and level
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // mssl_fifo

// File: hw/mssl_loader.v
`timescale 1ns/100ps
`include "mssl_map.vh"
// Behaviour
// R1: three modes: single-chip, self-check, factory test
// R2: normal interrupt level gives single-chip mode
// R3: test voltage and strap bit1 high: self-check
// R4: fixture holds reset long enough
// R5: self-check turns the pll on first
// R6: run io, ram, timer, rom, interrupt tests
// R7: report result codes on result lines
// R8: self-check program lives at 1F00-1FEF
// R9: timer test zero flag, accumulator zero
// R10: timer sampled every 12 cycles till flags
// R11: rom checksum at 1FD1, index zero
// R12: straps 0..3 pick the routine
// R13: bit2 high, bit3 low: pll stays off
// R14: bit2 low, bit1 high, bit0 low: jump ram
// R15: bit2 low, bit1 high, bit0 high: download
// R16: data-ready low: drop ack, store from 100
// R17: ack low after each byte stored
// R18: first byte is count, then execute
// R19: host waits for ack before next byte
module mssl_loader (
  input wire clk_i,
  input wire rst_i,
  input wire test_voltage_level_i,
  input wire irq_n_i,
  input wire port_b_bit0_strap_i,
  input wire port_b_bit1_strap_i,
  input wire port_b_bit2_strap_i,
  input wire port_b_bit3_strap_i,
  input wire [7:0] port_a_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [1:0] mode_o,
  output reg pll_on_o,
  output reg [3:0] result_lines_o,
  output reg download_ack_line_o,
  output reg download_ack_line_oe_o,
  output reg ram_we_o,
  output reg [12:0] ram_addr_o,
  output reg [7:0] ram_wdata_o,
  output reg exec_start_o,
  output reg [12:0] exec_addr_o,
  output reg zero_flag_o,
  output reg [7:0] acc_o,
  output reg [7:0] index_o
);
  // sequencer states: test phases plus idle, good, bad, download, start and halt
  localparam ST_IDLE = 4'h0;
  localparam ST_IO = 4'h1;
  localparam ST_RAM = 4'h2;
  localparam ST_TMR = 4'h3;
  localparam ST_ROM = 4'h4;
  localparam ST_INT = 4'h5;
  localparam ST_GOOD = 4'h6;
  localparam ST_BAD = 4'h7;
  localparam ST_DL = 4'h8;
  localparam ST_EXEC = 4'h9;
  localparam ST_HALT = 4'hA;

  // sample period of the prescaled timer, at least one cycle
  localparam [3:0] TMR_SAMPLE = `MSSL_TMR_SAMPLE_CYCLES;

  // decode strap bits to a routine; used at reset catch and status read
  function [2:0] pick_routine;
    input [3:0] s;
    begin
      if (s[2] & ~s[3]) begin
        pick_routine = `MSSL_RT_NOPLL;
      end else if (~s[2] & s[1] & ~s[0]) begin
        pick_routine = `MSSL_RT_JUMPRAM;
      end else if (~s[2] & s[1] & s[0]) begin
        pick_routine = `MSSL_RT_LOADRAM;
      end else begin
        pick_routine = `MSSL_RT_SELFCHK;
      end
    end
  endfunction

  reg [3:0] state_ff; // test sequencer state
  reg [2:0] routine_ff; // routine picked at reset release
  reg caught_ff; // straps already caught since reset
  reg [3:0] tmr_cnt_ff; // timer sample spacing counter
  reg [3:0] step_ff; // per-phase step counter
  reg [31:0] flash_ff; // led flash divider
  reg [7:0] dl_total_ff; // byte count from first byte
  reg [7:0] dl_seen_ff; // bytes received so far
  reg dl_first_ff; // next byte is the count
  reg irq_q_ff; // previous data-ready level
  reg [4:0] fault_ff; // software fault injection
  reg run_ff; // software asks to rerun tests
  wire [3:0] straps;
  wire dr_fall;
  wire fifo_in_ready;
  wire [7:0] fifo_data;
  wire fifo_valid;
  reg fifo_pop;
  wire bus_req;

  // strap pins gathered as one nibble, bit 0 lowest
  assign straps = {port_b_bit3_strap_i, port_b_bit2_strap_i,
                   port_b_bit1_strap_i, port_b_bit0_strap_i};
  // a byte is offered on the falling edge of data-ready
  assign dr_fall = irq_q_ff & ~irq_n_i & (state_ff == ST_DL);
  // a request that has not been answered yet
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // buffer download bytes; the full flag is unused, so a byte offered while full is dropped
  mssl_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(port_a_i),
    .in_valid_i(dr_fall),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // pop a byte whenever the writer is downloading
  always @* begin
    fifo_pop = fifo_valid & (state_ff == ST_DL);
  end

  // wishbone slave: one-cycle ack, unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      fault_ff <= 5'h00;
      run_ff <= 1'b0;
    end else begin
      // ack follows the request by one cycle, then drops
      wb_ack_o <= bus_req;
      // rerun request is a one-cycle strobe
      run_ff <= 1'b0;
      if (bus_req & wb_we_i & wb_sel_i[0]) begin
        case (wb_adr_i)
          `MSSL_REG_CTRL: begin
            // only the run bit matters here
            run_ff <= wb_dat_i[`MSSL_CTRL_RUN];
          end
          `MSSL_REG_TEST: begin
            fault_ff <= wb_dat_i[4:0];
          end
          default: begin
            // writes elsewhere are ignored
          end
        endcase
      end
      if (bus_req & ~wb_we_i) begin
        case (wb_adr_i)
          `MSSL_REG_STAT: begin
            // live strap pick sits beside the one caught at reset
            wb_dat_o <= {12'h000, state_ff, pick_routine(straps),
                         1'b0, routine_ff, 3'h0, mode_o,
                         result_lines_o};
          end
          `MSSL_REG_TEST: begin
            // fault bits read back as written
            wb_dat_o <= {27'h0000000, fault_ff};
          end
          `MSSL_REG_CNT: begin
            // download progress: total above, seen below
            wb_dat_o <= {16'h0000, dl_total_ff, dl_seen_ff};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // mode catch at reset release, then the self-check sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      // straps are caught on the first edge after release
      state_ff <= ST_IDLE;
      routine_ff <= `MSSL_RT_NONE;
      caught_ff <= 1'b0;
      mode_o <= `MSSL_MODE_SINGLE;
      pll_on_o <= 1'b0;
      result_lines_o <= `MSSL_RES_OFF;
      download_ack_line_o <= 1'b1;
      download_ack_line_oe_o <= 1'b0;
      ram_we_o <= 1'b0;
      ram_addr_o <= 13'h0000;
      ram_wdata_o <= 8'h00;
      exec_start_o <= 1'b0;
      exec_addr_o <= 13'h0000;
      zero_flag_o <= 1'b0;
      acc_o <= 8'h00;
      index_o <= 8'h00;
      tmr_cnt_ff <= 4'h0;
      step_ff <= 4'h0;
      flash_ff <= 32'h00000000;
      dl_total_ff <= 8'h00;
      dl_seen_ff <= 8'h00;
      dl_first_ff <= 1'b1;
      irq_q_ff <= 1'b1;
    end else begin
      // previous data-ready level for the falling-edge detect
      irq_q_ff <= irq_n_i;
      // store and start strobes last one cycle
      ram_we_o <= 1'b0;
      exec_start_o <= 1'b0;
      // R4 reset length assumed met by fixture
      if (!caught_ff) begin
        caught_ff <= 1'b1;
        // R1 three mode decode
        if (test_voltage_level_i & port_b_bit1_strap_i) begin
          // R3 self-check entry
          mode_o <= `MSSL_MODE_SELFCHK;
          // R12 strap routine pick
          routine_ff <= pick_routine(straps);
          // jump and download skip the test phases
          case (pick_routine(straps))
            `MSSL_RT_JUMPRAM: begin
              state_ff <= ST_EXEC;
            end
            `MSSL_RT_LOADRAM: begin
              // R15 download routine entry
              state_ff <= ST_DL;
              download_ack_line_oe_o <= 1'b1;
            end
            `MSSL_RT_NOPLL: begin
              // R13 pll left off
              state_ff <= ST_IO;
            end
            default: begin
              // R5 pll on first
              pll_on_o <= 1'b1;
              state_ff <= ST_IO;
            end
          endcase
        end else if (test_voltage_level_i) begin
          // factory test internals are not modelled, park
          mode_o <= `MSSL_MODE_FACTORY;
          state_ff <= ST_HALT;
        end else begin
          // R2 single-chip entry
          mode_o <= `MSSL_MODE_SINGLE;
          state_ff <= ST_HALT;
        end
      end else begin
        case (state_ff)
          // R6 ordered test phases
          ST_IO: begin
            // each phase but the interrupt one writes its code as it decides; the next phase overwrites it on a pass
            step_ff <= 4'h0;
            state_ff <= fault_ff[`MSSL_TEST_IO] ? ST_BAD : ST_RAM;
            result_lines_o <= `MSSL_RES_BAD_IO;
          end
          ST_RAM: begin
            // ram phase also arms the timer sampler
            state_ff <= fault_ff[`MSSL_TEST_RAM] ? ST_BAD : ST_TMR;
            result_lines_o <= `MSSL_RES_BAD_RAM;
            tmr_cnt_ff <= 4'h0;
          end
          ST_TMR: begin
            // R10 sample every 12 cycles
            if (tmr_cnt_ff == TMR_SAMPLE - 4'h1) begin
              tmr_cnt_ff <= 4'h0;
              step_ff <= step_ff + 4'h1;
              if (step_ff == 4'hF) begin
                // R9 zero flag and accumulator
                zero_flag_o <= ~fault_ff[`MSSL_TEST_TMR];
                acc_o <= fault_ff[`MSSL_TEST_TMR] ? 8'h01 : 8'h00;
                result_lines_o <= `MSSL_RES_BAD_TMR;
                state_ff <= fault_ff[`MSSL_TEST_TMR] ? ST_BAD : ST_ROM;
              end
            end else begin
              // count toward the next sample
              tmr_cnt_ff <= tmr_cnt_ff + 4'h1;
            end
          end
          ST_ROM: begin
            // R11 checksum return values
            index_o <= 8'h00;
            zero_flag_o <= ~fault_ff[`MSSL_TEST_ROM];
            acc_o <= fault_ff[`MSSL_TEST_ROM] ? 8'h01 : 8'h00;
            // R8 routine address window
            exec_addr_o <= `MSSL_ROMSUM_ENTRY;
            result_lines_o <= `MSSL_RES_BAD_ROM;
            state_ff <= fault_ff[`MSSL_TEST_ROM] ? ST_BAD : ST_INT;
          end
          ST_INT: begin
            if (fault_ff[`MSSL_TEST_INT]) begin
              result_lines_o <= `MSSL_RES_BAD_INT;
              state_ff <= ST_BAD;
            end else begin
              // good device: all leds on, the divider then flashes them
              result_lines_o <= `MSSL_RES_ON;
              flash_ff <= 32'h00000000;
              state_ff <= ST_GOOD;
            end
          end
          ST_GOOD: begin
            // R7 flashing means good device
            if (flash_ff == `MSSL_FLASH_HALF_CYCLES - 32'd1) begin
              flash_ff <= 32'h00000000;
              result_lines_o <= ~result_lines_o;
            end else begin
              flash_ff <= flash_ff + 32'd1;
            end
            // software rerun restarts at the io phase
            if (run_ff) begin
              state_ff <= ST_IO;
            end
          end
          ST_BAD: begin
            // R7 code stays on lines
            if (run_ff) begin
              state_ff <= ST_IO;
            end
          end
          ST_DL: begin
            // R16 byte taken, ack released
            if (dr_fall) begin
              download_ack_line_o <= 1'b1;
            end
            if (fifo_valid) begin
              // every byte is stored, the count included
              ram_we_o <= 1'b1;
              ram_wdata_o <= fifo_data;
              if (dl_first_ff) begin
                // R18 first byte is the count
                dl_first_ff <= 1'b0;
                dl_total_ff <= fifo_data;
                dl_seen_ff <= 8'h01;
                // count byte lands at the ram start
                ram_addr_o <= `MSSL_RAM_START;
              end else begin
                // next byte goes one address up
                ram_addr_o <= ram_addr_o + 13'h0001;
                dl_seen_ff <= dl_seen_ff + 8'h01;
              end
              // R17 ack low after store
              download_ack_line_o <= 1'b0;
              if (!dl_first_ff && dl_seen_ff + 8'h01 >= dl_total_ff) begin
                state_ff <= ST_EXEC;
              end else if (dl_first_ff && fifo_data <= 8'h01) begin
                state_ff <= ST_EXEC;
              end
            end
          end
          ST_EXEC: begin
            // R14 jump to ram start
            exec_start_o <= 1'b1;
            exec_addr_o <= `MSSL_RAM_START;
            state_ff <= ST_HALT;
          end
          ST_HALT: begin
            // single-chip and factory modes idle here
            state_ff <= ST_HALT;
          end
          default: begin
            // unknown codes park safely
            state_ff <= ST_HALT;
          end
        endcase
      end
    end
  end
endmodule // mssl_loader

// File: verif/mssl_loader_properties.sv
`timescale 1ns/100ps
`include "mssl_map.vh"
// watches loader pins: mode pick, download handshake, bus answer
module mssl_chk (
  input wire clk_i,
  input wire rst_i,
  input wire test_voltage_level_i,
  input wire irq_n_i,
  input wire port_b_bit1_strap_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [1:0] mode_o,
  input wire download_ack_line_o,
  input wire download_ack_line_oe_o,
  input wire ram_we_o,
  input wire [12:0] ram_addr_o,
  input wire exec_start_o,
  input wire [12:0] exec_addr_o
);
  reg [12:0] last_addr_ff; // address of the previous ram store
  // remember each store so the next one can be tied to it
  always @(posedge clk_i) begin
    if (rst_i) begin
      last_addr_ff <= 13'h0000;
    end else if (ram_we_o) begin
      last_addr_ff <= ram_addr_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_mode_single;
    $past(rst_i) && !test_voltage_level_i |=> mode_o == `MSSL_MODE_SINGLE;
  endproperty
  a_mode_single: assert property (p_mode_single)
    else $error("single mode not taken");
  property p_mode_self;
    $past(rst_i) && test_voltage_level_i && port_b_bit1_strap_i
      |=> mode_o == `MSSL_MODE_SELFCHK;
  endproperty
  a_mode_self: assert property (p_mode_self)
    else $error("self-check mode not taken");
  property p_mode_fact;
    $past(rst_i) && test_voltage_level_i && !port_b_bit1_strap_i
      |=> mode_o == `MSSL_MODE_FACTORY;
  endproperty
  a_mode_fact: assert property (p_mode_fact)
    else $error("factory mode not taken");
  property p_ack_seq;
    $fell(irq_n_i) && download_ack_line_oe_o
      |=> download_ack_line_o ##1 !download_ack_line_o;
  endproperty
  a_ack_seq: assert property (p_ack_seq)
    else $error("ack not released then asserted");
  property p_store_ack;
    $fell(download_ack_line_o) && download_ack_line_oe_o |-> ram_we_o;
  endproperty
  a_store_ack: assert property (p_store_ack)
    else $error("ack without a ram store");
  property p_ram_succ;
    ram_we_o && ram_addr_o != `MSSL_RAM_START
      |-> ram_addr_o == last_addr_ff + 13'h0001;
  endproperty
  a_ram_succ: assert property (p_ram_succ)
    else $error("ram store out of sequence");
  property p_exec_addr;
    exec_start_o |-> exec_addr_o == `MSSL_RAM_START;
  endproperty
  a_exec_addr: assert property (p_exec_addr)
    else $error("program start at wrong address");
  property p_single_quiet;
    mode_o == `MSSL_MODE_SINGLE
      |-> !ram_we_o && !exec_start_o && !download_ack_line_oe_o;
  endproperty
  a_single_quiet: assert property (p_single_quiet)
    else $error("activity seen in single mode");
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus answer not one cycle later");
  c_dl_ack: cover property ($fell(download_ack_line_o));
  c_exec: cover property (exec_start_o);
  c_fact: cover property (mode_o == `MSSL_MODE_FACTORY);
endmodule // mssl_chk
bind mssl_loader mssl_chk i_chk (.clk_i, .rst_i, .test_voltage_level_i,
  .irq_n_i, .port_b_bit1_strap_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .mode_o, .download_ack_line_o, .download_ack_line_oe_o, .ram_we_o,
  .ram_addr_o, .exec_start_o, .exec_addr_o);

// File: verif/mssl_host.sv
`timescale 1ns/100ps
// download host: shows a byte, pulls data-ready low, waits for ack
module mssl_host (
  input wire clk_i,
  input wire ack_n_i,
  output reg irq_n_o,
  output reg [7:0] data_o
);
  // idle: ready high, data line just noise
  initial begin
    irq_n_o = 1'b1;
    data_o = 8'h5A;
  end
  // gap stretches the idle time so a slow host is covered too
  task send(input logic [7:0] b, input integer gap);
    integer k;
    begin
      k = 0;
      data_o <= b;
      irq_n_o <= 1'b0;
      @(posedge clk_i);
      while (ack_n_i !== 1'b1 && k < 50) begin
        @(posedge clk_i);
        k = k + 1;
      end
      while (ack_n_i !== 1'b0 && k < 50) begin
        @(posedge clk_i);
        k = k + 1;
      end
      // released data shows the inverse, not a stale copy
      irq_n_o <= 1'b1;
      data_o <= ~b;
      repeat (gap + 1) @(posedge clk_i);
    end
  endtask
endmodule // mssl_host

// File: verif/mssl_loader_test.sv
`timescale 1ns/100ps
`include "mssl_map.vh"
// straps, bus and host drive the loader; pins are compared
module mssl_loader_test;
  typedef struct packed {
    logic tv;
    logic [3:0] st;
    logic [1:0] md;
    logic pll;
    logic ex;
  } mssl_row_t;
  mssl_row_t rows [5] = '{'{1'b0, 4'hE, 2'h0, 1'b0, 1'b0},
    '{1'b1, 4'hE, 2'h1, 1'b1, 1'b0}, '{1'b1, 4'hC, 2'h2, 1'b0, 1'b0},
    '{1'b1, 4'h6, 2'h1, 1'b0, 1'b0}, '{1'b1, 4'h2, 2'h1, 1'b0, 1'b1}};
  // fault bits above, result code below
  logic [8:0] faults [7] = '{9'h019, 9'h02A, 9'h04B, 9'h08C, 9'h10D,
    9'h06A, 9'h1F9};
  logic [7:0] bytes [4] = '{8'h04, 8'hA5, 8'h3C, 8'h81};
  logic clk_i, rst_i, tv, irq_n, we, cyc, stb, ack, pll, dack, doe;
  logic ram_we, ex_go, zf;
  logic [3:0] st, sel, res;
  logic [1:0] mode;
  logic [7:0] adr, pa, acc, idx, ram_d;
  logic [31:0] wdat, rdat, dat_o;
  logic [12:0] ram_a, ex_a;
  logic [12:0] wr_a [8];
  logic [7:0] wr_d [8];
  integer fails = 0, tests_run = 0, wn, exec_cnt, i, n;
  wire ack_pin = doe ? dack : 1'b1; // pull-up holds the idle ack high
  mssl_loader i_dut (.clk_i, .rst_i, .test_voltage_level_i(tv),
    .irq_n_i(irq_n), .port_b_bit0_strap_i(st[0]),
    .port_b_bit1_strap_i(st[1]), .port_b_bit2_strap_i(st[2]),
    .port_b_bit3_strap_i(st[3]), .port_a_i(pa), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .mode_o(mode),
    .pll_on_o(pll), .result_lines_o(res), .download_ack_line_o(dack),
    .download_ack_line_oe_o(doe), .ram_we_o(ram_we), .ram_addr_o(ram_a),
    .ram_wdata_o(ram_d), .exec_start_o(ex_go), .exec_addr_o(ex_a),
    .zero_flag_o(zf), .acc_o(acc), .index_o(idx));
  mssl_host i_host (.clk_i, .ack_n_i(ack_pin), .irq_n_o(irq_n),
    .data_o(pa));
  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // log ram stores and program starts
  always @(posedge clk_i) begin
    if (rst_i) begin
      wn <= 0;
      exec_cnt <= 0;
    end else begin
      if (ram_we === 1'b1 && wn < 8) begin
        wr_a[wn] <= ram_a;
        wr_d[wn] <= ram_d;
        wn <= wn + 1;
      end
      if (ex_go === 1'b1) exec_cnt <= exec_cnt + 1;
    end
  end
  task check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  // straps are caught at the first edge after release
  task do_reset(input logic t, input logic [3:0] s);
    rst_i <= 1'b1;
    tv <= t;
    st <= s;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one classic wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    check("bus ack", ack, 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, well beyond the longest fault wait
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    stop_test;
  end
  initial begin
    rst_i = 1'b1;
    tv = 1'b0;
    st = 4'h0;
    {we, cyc, stb} = 3'h0;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0;
    for (i = 0; i < 5; i++) begin
      do_reset(rows[i].tv, rows[i].st);
      repeat (20) @(posedge clk_i);
      check("mode", mode, rows[i].md);
      check("pll", pll, rows[i].pll);
      check("jump", exec_cnt, rows[i].ex);
      $display("mode row %0d done", i);
    end
    do_reset(1'b1, 4'hE);
    // a clean run ends with all leds on before the first flash toggle
    n = 0;
    while (res !== `MSSL_RES_ON && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    check("good", res, `MSSL_RES_ON);
    check("zero flag", zf, 1'b1);
    check("acc", acc, 8'h00);
    check("index", idx, 8'h00);
    for (i = 0; i < 7; i++) begin
      wb(1'b1, `MSSL_REG_TEST, {27'h0, faults[i][8:4]});
      wb(1'b1, `MSSL_REG_CTRL, 32'h00000001);
      n = 0;
      while (res !== faults[i][3:0] && n < 5000) begin
        @(posedge clk_i);
        n++;
      end
      // the code must stay, not merely pass by on its way
      repeat (250) @(posedge clk_i);
      check("result", res, faults[i][3:0]);
      if (i == 2 || i == 3) check("zero flag", zf, 1'b0);
    end
    wb(1'b0, `MSSL_REG_TEST, 32'h0);
    check("test reg", rdat, 32'h0000001F);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", rdat, 32'h0);
    $display("self-check faults done");
    do_reset(1'b1, 4'h3);
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      if (i == 3) check("early start", exec_cnt, 0);
      i_host.send(bytes[i], i);
    end
    n = 0;
    while (exec_cnt === 0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    check("start", exec_cnt, 1);
    check("start addr", ex_a, `MSSL_RAM_START);
    check("stores", wn, 4);
    for (i = 0; i < 4; i++) begin
      check("addr", wr_a[i], `MSSL_RAM_START + i);
      check("data", wr_d[i], bytes[i]);
    end
    wb(1'b0, `MSSL_REG_STAT, 32'h0);
    check("stat mode", rdat[5:4], 2'h1);
    check("routine", rdat[11:9], `MSSL_RT_LOADRAM);
    wb(1'b0, `MSSL_REG_CNT, 32'h0);
    check("total", rdat[15:8], 8'h04);
    check("seen", rdat[7:0], 8'h04);
    $display("download done");
    stop_test;
  end
endmodule // mssl_loader_test
